/* File: src/intc_prio_pkg.sv */
// Constants, field layout and state type for the priority level registers
`default_nettype none
package intc_prio_pkg;
    localparam int DATA_WIDTH = 32;
    localparam int REG_WIDTH = 16;
    localparam int ADDR_WIDTH = 6;
    localparam int SRC_COUNT = 17;

    // Register indices; byte address is four times the index
    localparam logic [3:0] DBG_IDX = 4'h1;
    localparam logic [3:0] SYS_IDX = 4'h2;
    localparam logic [3:0] PC_IDX = 4'h3;

    localparam logic [15:0] DBG_RESET = 16'h0000;
    localparam logic [15:0] SYS_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Writable bits of each register
    localparam logic [15:0] DBG_WMASK = 16'h003f;
    localparam logic [15:0] SYS_WMASK = 16'hffcf;
    localparam logic [15:0] PC_WMASK = 16'hfffc;

    localparam logic [1:0] FIELD_OFF = 2'h0;

    // Field positions
    localparam int DBG_RX_FULL_LSB = 4;
    localparam int DBG_TX_EMPTY_LSB = 2;
    localparam int DBG_TRACE_BUF_LSB = 0;
    localparam int FLASH_BUF_EMPTY_LSB = 14;
    localparam int FLASH_CMD_DONE_LSB = 12;
    localparam int FLASH_ERROR_LSB = 10;
    localparam int PLL_LOCK_LOSS_LSB = 8;
    localparam int LOW_VOLTAGE_LSB = 6;
    localparam int EXT_PIN_B_LSB = 2;
    localparam int EXT_PIN_A_LSB = 0;
    localparam int PORT_D_LSB = 14;
    localparam int PORT_E_LSB = 12;
    localparam int PORT_F_LSB = 10;
    localparam int CAN_MSG_BUF_LSB = 8;
    localparam int CAN_WAKE_LSB = 6;
    localparam int CAN_ERROR_LSB = 4;
    localparam int CAN_BUS_OFF_LSB = 2;

    // Source numbering; the first three are debug sources
    localparam int DBG_SRC_COUNT = 3;
    localparam logic [3:0] SRC_REG [SRC_COUNT] = '{
        DBG_IDX, DBG_IDX, DBG_IDX,
        SYS_IDX, SYS_IDX, SYS_IDX, SYS_IDX, SYS_IDX, SYS_IDX, SYS_IDX,
        PC_IDX, PC_IDX, PC_IDX, PC_IDX, PC_IDX, PC_IDX, PC_IDX};
    localparam int SRC_LSB [SRC_COUNT] = '{
        DBG_TRACE_BUF_LSB, DBG_TX_EMPTY_LSB, DBG_RX_FULL_LSB,
        EXT_PIN_A_LSB, EXT_PIN_B_LSB, LOW_VOLTAGE_LSB, PLL_LOCK_LOSS_LSB,
        FLASH_ERROR_LSB, FLASH_CMD_DONE_LSB, FLASH_BUF_EMPTY_LSB,
        CAN_BUS_OFF_LSB, CAN_ERROR_LSB, CAN_WAKE_LSB, CAN_MSG_BUF_LSB,
        PORT_F_LSB, PORT_E_LSB, PORT_D_LSB};

    typedef struct packed {
        logic wait_busy;
        logic [DATA_WIDTH-1:0] rdata;
        logic [REG_WIDTH-1:0] dbg;
        logic [REG_WIDTH-1:0] sys;
        logic [REG_WIDTH-1:0] pc;
        logic [SRC_COUNT-1:0] req;
        logic [SRC_COUNT-1:0][1:0] lvl;
    } state_t;

    localparam state_t ST_RESET = '{
        wait_busy: 1'b1, rdata: '0, dbg: DBG_RESET, sys: SYS_RESET,
        pc: PC_RESET, req: '0, lvl: '0};
endpackage
`default_nettype wire

/* File: src/interrupt_priority_level_regs.sv */
// Priority level registers with per-source request and level outputs
//
// What this block does
// - Bits 15..6 of the debug register and 5..4 of the system register read zero and ignore writes.
// - Debug fields map 00 to disabled and 01, 10, 11 to levels 1, 2, 3.
// - Debug register holds receive-full at 5..4, transmit-empty at 3..2, trace buffer at 1..0.
// - Other fields map 00 to disabled and 01, 10, 11 to levels 0, 1, 2.
// - System register holds flash buffers empty, command done, error, PLL lock loss, low voltage from 15 down to 6.
// - System register holds external pin B at 3..2 and pin A at 1..0.
// - Port/CAN register holds port D at 15..14, E at 13..12, F at 11..10.
// - Port/CAN register holds CAN message buffer at 9..8, wake at 7..6, error at 5..4.
// - Reset clears every field so all sources start disabled.
// - Port/CAN register holds CAN bus-off at 3..2 with the level 0 to 2 coding.
`default_nettype none
module interrupt_priority_level_regs
    import intc_prio_pkg::*;
#(
    parameter int ADDR_W = ADDR_WIDTH
)(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_WIDTH-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [DATA_WIDTH-1:0] readdata,
    output logic waitrequest,
    input wire logic [SRC_COUNT-1:0] src_event,
    output logic [SRC_COUNT-1:0] core_req,
    output logic [2*SRC_COUNT-1:0] core_level
);

    state_t st_q;
    state_t st_d;

    // Register index of an aligned address, zero when misaligned
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] idx;
        idx = a >> 2;
        if (a[1:0] != 2'h0 || idx > ADDR_W'(PC_IDX)) begin
            return 4'h0;
        end
        return idx[3:0];
    endfunction

    // Byte-lane and writable-bit merge of a write
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] be,
                                          input logic [15:0] wmask);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}} & wmask;
        return (old & ~m) | (wd & m);
    endfunction

    // Field of one source out of the three registers
    function automatic logic [1:0] field_of(input logic [15:0] dbg,
                                            input logic [15:0] sys,
                                            input logic [15:0] pc,
                                            input int src);
        logic [15:0] r;
        r = (SRC_REG[src] == DBG_IDX) ? dbg :
            (SRC_REG[src] == SYS_IDX) ? sys : pc;
        return 2'(r >> SRC_LSB[src]);
    endfunction

    // Level coding: debug sources 1..3, all others 0..2
    function automatic logic [1:0] decode(input logic [1:0] f,
                                          input int src);
        if (f == FIELD_OFF) begin
            return 2'h0;
        end
        if (src < DBG_SRC_COUNT) begin
            return f;
        end
        return f - 2'h1;
    endfunction

    always_comb begin
        logic [1:0] f;
        f = FIELD_OFF;
        st_d = st_q;
        st_d.wait_busy = 1'b1;
        if ((read || write) && st_q.wait_busy) begin
            // Answer one cycle after the request is seen
            st_d.wait_busy = 1'b0;
            st_d.rdata = '0;
            if (read) begin
                case (reg_sel(address))
                    DBG_IDX: st_d.rdata = {16'h0000, st_q.dbg};
                    SYS_IDX: st_d.rdata = {16'h0000, st_q.sys};
                    PC_IDX: st_d.rdata = {16'h0000, st_q.pc};
                    default: st_d.rdata = '0;
                endcase
            end
        end else if (write && !st_q.wait_busy) begin
            // Write lands on the edge that completes the transfer
            case (reg_sel(address))
                DBG_IDX: begin
                    st_d.dbg = merge(st_q.dbg, writedata[15:0],
                                     byteenable[1:0], DBG_WMASK);
                end
                SYS_IDX: begin
                    st_d.sys = merge(st_q.sys, writedata[15:0],
                                     byteenable[1:0], SYS_WMASK);
                end
                PC_IDX: begin
                    st_d.pc = merge(st_q.pc, writedata[15:0],
                                    byteenable[1:0], PC_WMASK);
                end
                default: begin
                    st_d.pc = st_q.pc;
                end
            endcase
        end
        // Per-source request and level toward the core
        for (int i = 0; i < SRC_COUNT; i++) begin
            f = field_of(st_q.dbg, st_q.sys, st_q.pc, i);
            st_d.req[i] = src_event[i] && (f != FIELD_OFF);
            st_d.lvl[i] = st_d.req[i] ? decode(f, i) : 2'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign readdata = st_q.rdata;
    assign waitrequest = st_q.wait_busy;
    assign core_req = st_q.req;
    assign core_level = st_q.lvl;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_request;
        (read || write) && waitrequest;
    endsequence

    sequence s_wr_full(logic [3:0] idx);
        write && !waitrequest && reg_sel(address) == idx
            && byteenable[1:0] == 2'h3;
    endsequence

    sequence s_rd_done(logic [3:0] idx);
        read && !waitrequest && reg_sel(address) == idx;
    endsequence

    a_wait_answer: assert property (s_request |=> !waitrequest)
        else $error("waitrequest did not drop after a request");

    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest stayed low for two cycles");

    a_dbg_reserved: assert property (
        s_wr_full(DBG_IDX) |=> st_q.dbg[15:6] == 10'h000
            && st_q.dbg[5:0] == $past(writedata[5:0]))
        else $error("debug register reserved bits or fields wrong");

    a_sys_reserved: assert property (
        s_rd_done(SYS_IDX) |-> readdata[5:4] == 2'h0
            && readdata[31:16] == 16'h0000)
        else $error("system register reserved bits not zero");

    a_dbg_levels: assert property (
        core_req[DBG_SRC_COUNT-1:0] != '0 |->
            core_level[1:0] != 2'h0 || !core_req[0])
        else $error("debug source requested at level 0");

    a_dbg_fields: assert property (
        s_wr_full(DBG_IDX) ##1 (src_event[2:0] == 3'h7) |=>
            core_level[5:0] == {$past(st_q.dbg[5:4]),
                                $past(st_q.dbg[3:2]),
                                $past(st_q.dbg[1:0])})
        else $error("debug field order wrong");

    a_other_levels: assert property (
        core_req[3] |-> core_level[7:6] ==
            2'($past(st_q.sys[EXT_PIN_A_LSB+:2]) - 2'h1))
        else $error("non-debug level coding wrong");

    a_sys_store: assert property (
        s_wr_full(SYS_IDX) |=> st_q.sys ==
            ($past(writedata[15:0]) & SYS_WMASK))
        else $error("system register store wrong");

    a_sys_pins: assert property (
        s_wr_full(SYS_IDX) ##1 src_event[4:3] == 2'h3 |=>
            core_req[4] == ($past(st_q.sys[3:2]) != 2'h0)
            && core_req[3] == ($past(st_q.sys[1:0]) != 2'h0))
        else $error("external pin fields misplaced");

    a_pc_ports: assert property (
        s_wr_full(PC_IDX) |=> st_q.pc[15:10] ==
            $past(writedata[15:10]))
        else $error("port fields not stored");

    a_pc_can: assert property (
        s_wr_full(PC_IDX) |=> st_q.pc[9:4] == $past(writedata[9:4])
            && st_q.pc[1:0] == 2'h0)
        else $error("CAN fields not stored");

    a_reset_idle: assert property (
        $past(rst_b) == 1'b0 |-> st_q.dbg == DBG_RESET
            && st_q.sys == SYS_RESET && st_q.pc == PC_RESET
            && core_req == '0)
        else $error("registers not cleared by reset");

    a_bus_off: assert property (
        core_req[10] |-> core_level[21:20] != 2'h3
            && $past(st_q.pc[CAN_BUS_OFF_LSB+:2]) != 2'h0)
        else $error("bus-off level out of range");

    a_off_silent: assert property (
        core_req != '0 |-> $past(src_event) != '0)
        else $error("request without a source event");

    a_req_level: assert property (
        !core_req[16] |-> core_level[33:32] == 2'h0)
        else $error("level shown for an idle source");

endmodule
`default_nettype wire

/* File: tb/core_model.sv */
// Behavioural core that captures prioritized requests each cycle
`default_nettype none
module core_model
    import intc_prio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [SRC_COUNT-1:0] core_req,
    input wire logic [2*SRC_COUNT-1:0] core_level,
    output logic [SRC_COUNT-1:0] taken_req,
    output logic [2*SRC_COUNT-1:0] taken_level
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            taken_req <= '0;
            taken_level <= '0;
        end else begin
            taken_req <= core_req;
            taken_level <= core_level;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the priority level registers
`default_nettype none
module tb
    import intc_prio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_b, read, write, waitrequest;
    logic [5:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic [16:0] src_event, core_req, taken_req;
    logic [33:0] core_level, taken_level;
    int err_total, compares, cyc;
    // Field position of each source, in source order
    int lsb_tab [17] = '{0, 2, 4, 0, 2, 6, 8, 10, 12, 14, 2, 4, 6, 8, 10,
        12, 14};

    interrupt_priority_level_regs uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .src_event(src_event), .core_req(core_req),
        .core_level(core_level));
    core_model core (.ref_clk(ref_clk), .rst_b(rst_b), .core_req(core_req),
        .core_level(core_level), .taken_req(taken_req),
        .taken_level(taken_level));

    always #5 ref_clk = ~ref_clk;

    task automatic test_done;
        $display("Checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            test_done;
        end
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        chk({2'h0, q}, {2'h0, exp});
    endtask

    task automatic t_reset;
        rd_chk(6'h04, 32'h0000_0000);
        rd_chk(6'h08, 32'h0000_0000);
        rd_chk(6'h0c, 32'h0000_0000);
        chk({17'h0_0000, taken_req}, 34'h0);
    endtask

    task automatic t_reserved;
        for (int r = 1; r < 4; r++) begin
            bus(1'b1, 6'(4 * r), 32'hffff_ffff, 4'hf);
        end
        rd_chk(6'h04, 32'h0000_003f);
        rd_chk(6'h08, 32'h0000_ffcf);
        rd_chk(6'h0c, 32'h0000_fffc);
        rd_chk(6'h00, 32'h0000_0000);
        rd_chk(6'h10, 32'h0000_0000);
        bus(1'b1, 6'h0c, 32'h0000_0000, 4'h1);
        rd_chk(6'h0c, 32'h0000_ff00);
        src_event <= '0;
        repeat (3) @(negedge ref_clk);
        chk({17'h0_0000, taken_req}, 34'h0);
        src_event <= '1;
        for (int r = 1; r < 4; r++) begin
            bus(1'b1, 6'(4 * r), 32'h0000_0000, 4'hf);
        end
    endtask

    task automatic t_levels;
        int r;
        logic [1:0] lvl;
        for (int i = 0; i < 17; i++) begin
            r = (i < 3) ? 1 : ((i < 10) ? 2 : 3);
            for (int v = 0; v < 4; v++) begin
                bus(1'b1, 6'(4 * r), 32'(v) << lsb_tab[i], 4'hf);
                repeat (3) @(negedge ref_clk);
                lvl = (v == 0) ? 2'h0 : ((i < 3) ? 2'(v) : 2'(v - 1));
                chk({17'h0, taken_req}, (v != 0) ? 34'h1 << i : 34'h0);
                chk(taken_level, 34'(lvl) << (2 * i));
            end
            bus(1'b1, 6'(4 * r), 32'h0000_0000, 4'hf);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        src_event = '1;
        err_total = 0;
        compares = 0;
        cyc = 0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset;
        t_reserved;
        t_levels;
        test_done;
    end
endmodule
`default_nettype wire
